// file: hdl/crs_regfile.sv
// CPU register set with address decode, reached over AXI4-Lite
// How it works
// - 28 registers; data, address and both bases banked by flag bit 4
// - Four 16-bit data registers, read and written as words
// - First two data registers also reachable as separate high and low bytes
// - Third:first and fourth:second data registers form 32-bit pairs
// - Two 24-bit address registers, also bases for indirect and relative addressing
// - 24-bit static base gives the base of static-relative addressing
// - 24-bit frame base gives the base of frame-relative addressing
// - 24-bit instruction pointer holds the next instruction address
// - 24-bit vector table base for relocatable peripheral vectors
// - Separate 24-bit user and interrupt stack pointers, chosen by flag bit 7
// - Select bit zero uses interrupt stack, one uses user stack
// - Fast interrupt copies flag word into its 16-bit save register
// - Fast interrupt copies instruction pointer into its 24-bit save register
// - Fast interrupt loads instruction pointer from the 24-bit vector register
// - Addresses wrap within a 16-megabyte space; program high, data low
// - Fixed vectors, reset and nonmaskable included, sit at the top region
// - Lowest kilobyte decodes as peripheral area, never general memory
// - Special page vector region supports two-byte calls and jumps
// - Nonmaskable input fires on high-to-low edge, cannot be disabled
// - Expansion and processor modes block certain ranges from external access
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module crs_regfile
   import crs_pkg::*;
#(
   parameter int AW = 8,
   parameter logic [23:0] ROM_LO = 24'hfe0000,
   parameter logic [23:0] RSV_A_LO = 24'h002c00,
   parameter logic [23:0] RSV_A_HI = 24'h008000,
   parameter logic [23:0] RSV_B_LO = 24'hf00000,
   parameter logic [23:0] RSV_B_HI = 24'hfdffff
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic nonmaskable_irq_pin,
   output logic nmi_pending,
   output logic fast_irq_active
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction : mrg

   // Offset is aligned, in range and has no high bits set
   function automatic logic mapped(input logic [AW-1:0] a);
      return (a[1:0] == 2'b00) && (a <= AW'(OFF_PMODE));
   endfunction : mapped

   // Region that an address falls into
   function automatic crs_rgn_t region(input logic [23:0] a);
      if (a <= PERIPH_TOP)
         return RG_PERIPH;
      else if (a >= FIXVEC_BASE)
         return RG_FIXVEC;
      else if (a >= SPAGE_BASE)
         return RG_SPAGE;
      else if (a >= ROM_LO)
         return RG_PROG;
      else
         return RG_DATA;
   endfunction : region

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [15:0] data_r [2][4];
   logic [23:0] addr_r [2][2];
   logic [23:0] sbase_r [2];
   logic [23:0] fbase_r [2];
   logic [23:0] iptr_r, vtb_r, ustk_r, istk_r, psave_r, fvec_r;
   logic [15:0] flag_r, fsave_r;
   logic [27:0] ea_res_r;
   crs_pmode_t pmode_r;
   logic nmi_s1_r, nmi_s2_r, nmi_d_r;
   logic bk;
   logic [23:0] astk;

   assign bk = flag_r[FLG_BANK];
   assign astk = flag_r[FLG_USEL] ? ustk_r : istk_r;

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   logic aw_got_r, w_got_r, aw_hs, w_hs, wr_go;
   logic [AW-1:0] wa_r;
   logic [31:0] wd_r;
   logic [3:0] ws_r;
   logic [7:0] wa;

   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign wr_go = aw_got_r && w_got_r && !bvalid;
   assign wa = wa_r[7:0];

   // Address and data may come in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         wa_r <= '0;
         wd_r <= 32'h00000000;
         ws_r <= 4'h0;
      end
      else
      begin
         awready <= !aw_hs && !aw_got_r && !bvalid;
         wready <= !w_hs && !w_got_r && !bvalid;
         if (aw_hs)
         begin
            aw_got_r <= 1'b1;
            wa_r <= awaddr;
         end
         else if (wr_go)
            aw_got_r <= 1'b0;
         if (w_hs)
         begin
            w_got_r <= 1'b1;
            wd_r <= wdata;
            ws_r <= wstrb;
         end
         else if (wr_go)
            w_got_r <= 1'b0;
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid <= 1'b1;
         bresp <= mapped(wa_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Write strobes per target; unmapped writes are dropped
   logic wr_ok, enter, leave;
   assign wr_ok = wr_go && mapped(wa_r);
   assign enter = wr_ok && wa == OFF_CTRL && ws_r[0] && wd_r[CTRL_ENTER];
   assign leave = wr_ok && wa == OFF_CTRL && ws_r[0] && wd_r[CTRL_RET] && !enter;

   // ************************************************************
   // Banked data registers and their views
   // ************************************************************
   // word writes; byte views; long pairs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int b = 0; b < 2; b++)
            for (int i = 0; i < 4; i++)
               data_r[b][i] <= RST_WORD[15:0];
      end
      else if (wr_ok)
      begin
         if (wa <= OFF_DATA3)
            data_r[bk][wa[3:2]] <= 16'(mrg({16'h0000, data_r[bk][wa[3:2]]}, wd_r, ws_r));
         else if (wa == OFF_D0LO && ws_r[0])
            data_r[bk][0][7:0] <= wd_r[7:0];
         else if (wa == OFF_D0HI && ws_r[0])
            data_r[bk][0][15:8] <= wd_r[7:0];
         else if (wa == OFF_D1LO && ws_r[0])
            data_r[bk][1][7:0] <= wd_r[7:0];
         else if (wa == OFF_D1HI && ws_r[0])
            data_r[bk][1][15:8] <= wd_r[7:0];
         else if (wa == OFF_PAIRLO)
            {data_r[bk][2], data_r[bk][0]} <= mrg({data_r[bk][2], data_r[bk][0]}, wd_r, ws_r);
         else if (wa == OFF_PAIRHI)
            {data_r[bk][3], data_r[bk][1]} <= mrg({data_r[bk][3], data_r[bk][1]}, wd_r, ws_r);
      end
   end

   // ************************************************************
   // Banked address and base registers
   // ************************************************************
   // banked 24-bit bases
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int b = 0; b < 2; b++)
         begin
            addr_r[b][0] <= RST_WORD;
            addr_r[b][1] <= RST_WORD;
            sbase_r[b] <= RST_WORD;
            fbase_r[b] <= RST_WORD;
         end
      end
      else if (wr_ok)
      begin
         if (wa == OFF_ADDR0 || wa == OFF_ADDR1)
            addr_r[bk][wa[2]] <= 24'(mrg({8'h00, addr_r[bk][wa[2]]}, wd_r, ws_r));
         else if (wa == OFF_SBASE)
            sbase_r[bk] <= 24'(mrg({8'h00, sbase_r[bk]}, wd_r, ws_r));
         else if (wa == OFF_FBASE)
            fbase_r[bk] <= 24'(mrg({8'h00, fbase_r[bk]}, wd_r, ws_r));
      end
   end

   // ************************************************************
   // Stack pointers, vector base and fast vector
   // ************************************************************
   // plain 24-bit pointers; the active view writes whichever is chosen
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vtb_r <= RST_WORD;
         ustk_r <= RST_WORD;
         istk_r <= RST_WORD;
         fvec_r <= RST_WORD;
      end
      else if (wr_ok)
      begin
         if (wa == OFF_VTB)
            vtb_r <= 24'(mrg({8'h00, vtb_r}, wd_r, ws_r));
         if (wa == OFF_USTK || (wa == OFF_ASTK && flag_r[FLG_USEL]))
            ustk_r <= 24'(mrg({8'h00, ustk_r}, wd_r, ws_r));
         if (wa == OFF_ISTK || (wa == OFF_ASTK && !flag_r[FLG_USEL]))
            istk_r <= 24'(mrg({8'h00, istk_r}, wd_r, ws_r));
         if (wa == OFF_FVEC)
            fvec_r <= 24'(mrg({8'h00, fvec_r}, wd_r, ws_r));
      end
   end

   // ************************************************************
   // Instruction pointer, flags and fast interrupt saves
   // ************************************************************
   // Save copies avoid any stack traffic, so entry and return take one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         iptr_r <= RST_WORD;
         flag_r <= RST_FLAG;
         fsave_r <= RST_FLAG;
         psave_r <= RST_WORD;
         fast_irq_active <= 1'b0;
      end
      else if (enter)
      begin
         fsave_r <= flag_r;
         psave_r <= iptr_r;
         iptr_r <= fvec_r;
         flag_r <= flag_r & ~(16'h0001 << FLG_USEL) & ~(16'h0001 << FLG_IEN);
         fast_irq_active <= 1'b1;
      end
      else if (leave)
      begin
         iptr_r <= psave_r;
         flag_r <= fsave_r & FLG_MASK;
         fast_irq_active <= 1'b0;
      end
      else if (wr_ok)
      begin
         if (wa == OFF_IPTR)
            iptr_r <= 24'(mrg({8'h00, iptr_r}, wd_r, ws_r));
         if (wa == OFF_FLAGW)
            flag_r <= 16'(mrg({16'h0000, flag_r}, wd_r, ws_r)) & FLG_MASK;
         if (wa == OFF_FSAVE)
            fsave_r <= 16'(mrg({16'h0000, fsave_r}, wd_r, ws_r));
         if (wa == OFF_PSAVE)
            psave_r <= 24'(mrg({8'h00, psave_r}, wd_r, ws_r));
      end
   end

   // ************************************************************
   // Effective address unit and processor mode
   // ************************************************************
   logic [23:0] ea_base, ea_addr;
   logic [23:0] disp;
   logic ea_blk;
   assign disp = {{8{wd_r[15]}}, wd_r[15:0]};

   always_comb
   begin
      unique case (crs_eam_t'(wd_r[18:16]))
         EA_ADDR0: ea_base = addr_r[bk][0];
         EA_ADDR1: ea_base = addr_r[bk][1];
         EA_SBASE: ea_base = sbase_r[bk];
         EA_FBASE: ea_base = fbase_r[bk];
         EA_FIXVEC: ea_base = FIXVEC_BASE;
         EA_SPAGE: ea_base = SPAGE_BASE;
         EA_STACK: ea_base = astk;
         default: ea_base = RST_WORD;
      endcase
   end

   // modulo 16 Mbyte sum; vector modes scale the index
   always_comb
   begin
      if (wd_r[18:16] == EA_FIXVEC)
         ea_addr = 24'(ea_base + {wd_r[15:0], 2'b00});
      else if (wd_r[18:16] == EA_SPAGE)
         ea_addr = 24'(ea_base + {wd_r[15:0], 1'b0});
      else
         ea_addr = 24'(ea_base + disp);
   end

   // range A blocks external access outside single-chip mode; range B only in expansion mode
   assign ea_blk = (pmode_r != PM_SINGLE && ea_addr >= RSV_A_LO && ea_addr <= RSV_A_HI)
      || (pmode_r == PM_EXPAND && ea_addr >= RSV_B_LO && ea_addr <= RSV_B_HI);

   // region tag stored with the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ea_res_r <= 28'h0000000;
         pmode_r <= PM_SINGLE;
      end
      else if (wr_ok && wa == OFF_EACMD)
         ea_res_r <= {ea_blk, region(ea_addr), ea_addr};
      else if (wr_ok && wa == OFF_PMODE && ws_r[0] && wd_r[1:0] != 2'b11)
         pmode_r <= crs_pmode_t'(wd_r[1:0]);
   end

   // ************************************************************
   // Nonmaskable input
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nmi_s1_r <= 1'b1;
         nmi_s2_r <= 1'b1;
         nmi_d_r <= 1'b1;
      end
      else
      begin
         nmi_s1_r <= nonmaskable_irq_pin;
         nmi_s2_r <= nmi_s1_r;
         nmi_d_r <= nmi_s2_r;
      end
   end

   // falling edge sets; no mask; set beats clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nmi_pending <= 1'b0;
      else if (nmi_d_r && !nmi_s2_r)
         nmi_pending <= 1'b1;
      else if (wr_ok && wa == OFF_STAT && ws_r[0] && wd_r[STAT_NMI])
         nmi_pending <= 1'b0;
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   logic [31:0] rv;
   logic [7:0] ra;
   assign ra = araddr[7:0];

   // Read mux; write-only and reserved bits read as zero
   always_comb
   begin
      rv = 32'h00000000;
      if (ra <= OFF_DATA3)
         rv = {16'h0000, data_r[bk][ra[3:2]]};
      else if (ra == OFF_ADDR0 || ra == OFF_ADDR1)
         rv = {8'h00, addr_r[bk][ra[2]]};
      else if (ra == OFF_SBASE)
         rv = {8'h00, sbase_r[bk]};
      else if (ra == OFF_FBASE)
         rv = {8'h00, fbase_r[bk]};
      else if (ra == OFF_IPTR)
         rv = {8'h00, iptr_r};
      else if (ra == OFF_VTB)
         rv = {8'h00, vtb_r};
      else if (ra == OFF_USTK)
         rv = {8'h00, ustk_r};
      else if (ra == OFF_ISTK)
         rv = {8'h00, istk_r};
      else if (ra == OFF_FLAGW)
         rv = {16'h0000, flag_r};
      else if (ra == OFF_FSAVE)
         rv = {16'h0000, fsave_r};
      else if (ra == OFF_PSAVE)
         rv = {8'h00, psave_r};
      else if (ra == OFF_FVEC)
         rv = {8'h00, fvec_r};
      else if (ra == OFF_ASTK)
         rv = {8'h00, astk};
      else if (ra == OFF_D0LO)
         rv = {24'h000000, data_r[bk][0][7:0]};
      else if (ra == OFF_D0HI)
         rv = {24'h000000, data_r[bk][0][15:8]};
      else if (ra == OFF_D1LO)
         rv = {24'h000000, data_r[bk][1][7:0]};
      else if (ra == OFF_D1HI)
         rv = {24'h000000, data_r[bk][1][15:8]};
      else if (ra == OFF_PAIRLO)
         rv = {data_r[bk][2], data_r[bk][0]};
      else if (ra == OFF_PAIRHI)
         rv = {data_r[bk][3], data_r[bk][1]};
      else if (ra == OFF_STAT)
         rv = {30'h00000000, fast_irq_active, nmi_pending};
      else if (ra == OFF_EARES)
         rv = {4'h0, ea_res_r};
      else if (ra == OFF_PMODE)
         rv = {30'h00000000, pmode_r};
   end

   // Data registered at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end
      else
      begin
         arready <= !(arvalid && arready) && !rvalid;
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= mapped(araddr) ? rv : 32'h00000000;
            rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_enter;
      enter ##1 fast_irq_active;
   endsequence

   a_fast_entry_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
      enter |=> iptr_r == $past(fvec_r) && psave_r == $past(iptr_r))
      else $error("fast entry pointer swap wrong");
   a_fast_entry_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      s_enter |-> fsave_r == $past(flag_r) && !flag_r[FLG_USEL])
      else $error("fast entry flag save wrong");
   a_fast_ret_restore: assert property (@(posedge aclk) disable iff (!aresetn)
      leave |=> iptr_r == $past(psave_r) && flag_r == ($past(fsave_r) & FLG_MASK) && !fast_irq_active)
      else $error("fast return did not restore pointer");
   a_nmi_edge_set: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(nmi_s2_r) |=> nmi_pending)
      else $error("falling edge lost");
   a_stack_sel_read: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr == AW'(OFF_ASTK) && !flag_r[FLG_USEL] && !wr_ok
      |=> rdata[23:0] == istk_r)
      else $error("wrong stack pointer active");
   a_byte_view_high: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ok && wa == OFF_D0HI && ws_r[0] |=> data_r[$past(bk)][0][15:8] == $past(wd_r[7:0])
      && data_r[$past(bk)][0][7:0] == $past(data_r[bk][0][7:0]))
      else $error("byte view disturbed other byte");
   a_pair_low_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ok && wa == OFF_PAIRLO && ws_r == 4'hf |=> data_r[$past(bk)][2] == $past(wd_r[31:16]))
      else $error("pair high half wrong");
   a_periph_region: assert property (@(posedge aclk) disable iff (!aresetn)
      ea_res_r[23:0] <= PERIPH_TOP |-> ea_res_r[26:24] == RG_PERIPH)
      else $error("low kilobyte not peripheral");
   // Both halves held must give a response next edge and close the readies
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go |=> bvalid && !aw_got_r && !w_got_r && !awready && !wready)
      else $error("write not answered");
endmodule : crs_regfile
`default_nettype wire

// file: inc/crs_pkg.sv
// Constants and types for the CPU register set block
package crs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_DATA0 = 8'h00;
   localparam logic [7:0] OFF_DATA3 = 8'h0c;
   localparam logic [7:0] OFF_ADDR0 = 8'h10;
   localparam logic [7:0] OFF_ADDR1 = 8'h14;
   localparam logic [7:0] OFF_SBASE = 8'h18;
   localparam logic [7:0] OFF_FBASE = 8'h1c;
   localparam logic [7:0] OFF_IPTR = 8'h20;
   localparam logic [7:0] OFF_VTB = 8'h24;
   localparam logic [7:0] OFF_USTK = 8'h28;
   localparam logic [7:0] OFF_ISTK = 8'h2c;
   localparam logic [7:0] OFF_FLAGW = 8'h30;
   localparam logic [7:0] OFF_FSAVE = 8'h34;
   localparam logic [7:0] OFF_PSAVE = 8'h38;
   localparam logic [7:0] OFF_FVEC = 8'h3c;
   localparam logic [7:0] OFF_ASTK = 8'h40;
   localparam logic [7:0] OFF_D0LO = 8'h44;
   localparam logic [7:0] OFF_D0HI = 8'h48;
   localparam logic [7:0] OFF_D1LO = 8'h4c;
   localparam logic [7:0] OFF_D1HI = 8'h50;
   localparam logic [7:0] OFF_PAIRLO = 8'h54;
   localparam logic [7:0] OFF_PAIRHI = 8'h58;
   localparam logic [7:0] OFF_CTRL = 8'h5c;
   localparam logic [7:0] OFF_STAT = 8'h60;
   localparam logic [7:0] OFF_EACMD = 8'h64;
   localparam logic [7:0] OFF_EARES = 8'h68;
   localparam logic [7:0] OFF_PMODE = 8'h6c;
   // Field positions
   localparam int FLG_BANK = 4;
   localparam int FLG_IEN = 6;
   localparam int FLG_USEL = 7;
   localparam logic [15:0] FLG_MASK = 16'h70ff;
   localparam int CTRL_ENTER = 0;
   localparam int CTRL_RET = 1;
   localparam int STAT_NMI = 0;
   localparam int STAT_FAST = 1;
   // Reset values
   localparam logic [15:0] RST_FLAG = 16'h0000;
   localparam logic [23:0] RST_WORD = 24'h000000;
   // Address space landmarks
   localparam logic [23:0] PERIPH_TOP = 24'h0003ff;
   localparam logic [23:0] SPAGE_BASE = 24'hfffe00;
   localparam logic [23:0] SPAGE_TOP = 24'hffffdb;
   localparam logic [23:0] FIXVEC_BASE = 24'hffffdc;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {PM_SINGLE = 2'b00, PM_EXPAND = 2'b01, PM_MPROC = 2'b10} crs_pmode_t;
   typedef enum logic [2:0] {EA_ADDR0 = 3'b000, EA_ADDR1 = 3'b001, EA_SBASE = 3'b010, EA_FBASE = 3'b011,
      EA_FIXVEC = 3'b100, EA_SPAGE = 3'b101, EA_STACK = 3'b110} crs_eam_t;
   typedef enum logic [2:0] {RG_PERIPH = 3'b000, RG_DATA = 3'b001, RG_PROG = 3'b010, RG_SPAGE = 3'b011,
      RG_FIXVEC = 3'b100} crs_rgn_t;
endpackage : crs_pkg

// file: sim/testbench.sv
// Self-checking bench for the CPU register set block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import crs_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, ga, gw, ta, tw;
   logic arvalid, arready, rvalid, rready, nmi_pin, nmi_pending, fast_irq_active;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int n_mismatch, n_compared;
   crs_regfile DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .nonmaskable_irq_pin(nmi_pin), .nmi_pending(nmi_pending),
      .fast_irq_active(fast_irq_active));
   // ************
   // Bus tasks
   // ************
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk
   // Halves released one by one as each is taken; ready looked at mid-cycle
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hf};
      {awvalid, wvalid, bready, ta, tw} <= 5'h1c;
      do
      begin
         @(negedge aclk);
         {ga, gw} = {awvalid & awready, wvalid & wready};
         @(posedge aclk);
         if (ga) awvalid <= 1'h0;
         if (gw) wvalid <= 1'h0;
         {ta, tw} = {ta | ga, tw | gw};
      end while (!(ta && tw));
      do @(negedge aclk); while (!bvalid);
      resp = bresp;
      @(posedge aclk);
      bready <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'h0;
      do @(negedge aclk); while (!rvalid);
      {rd_val, resp} = {rdata, rresp};
      @(posedge aclk);
      rready <= 1'h0;
   endtask : rd
   task rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_val, e);
   endtask : rc
   // ************
   // End of run
   // ************
   task end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end
   // Roughly 90 transfers of under 10 cycles; generous margin
   initial
   begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
   // ************
   // Test sequence
   // ************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      nmi_pin = 1'h1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rc(OFF_FLAGW, 32'h0);
      wr(OFF_DATA0, 32'hffffffff);
      rc(OFF_DATA0, 32'h0000ffff);
      // Every 24-bit register from the first address register up to the irq stack
      for (int i = 0; i < 8; i++)
      begin
         wr(OFF_ADDR0 + 8'(4 * i), 32'hffffffff);
         rc(OFF_ADDR0 + 8'(4 * i), 32'h00ffffff);
      end
      wr(OFF_D0LO, 32'h000000a5);
      wr(OFF_D0HI, 32'h0000003c);
      rc(OFF_DATA0, 32'h00003ca5);
      wr(OFF_D1HI, 32'h0000007e);
      rc(8'h04, 32'h00007e00);
      wr(OFF_PAIRLO, 32'h12345678);
      rc(8'h08, 32'h00001234);
      rc(OFF_DATA0, 32'h00005678);
      wr(OFF_PAIRHI, 32'h9abcdef0);
      rc(OFF_DATA3, 32'h00009abc);
      rc(8'h04, 32'h0000def0);
      // Second bank must not disturb the first
      wr(OFF_FLAGW, 32'h10);
      wr(OFF_DATA0, 32'h2222);
      wr(OFF_ADDR0, 32'h222222);
      wr(OFF_FLAGW, 32'h0);
      rc(OFF_DATA0, 32'h00005678);
      rc(OFF_ADDR0, 32'h00ffffff);
      wr(OFF_FLAGW, 32'h10);
      rc(OFF_DATA0, 32'h00002222);
      wr(OFF_FLAGW, 32'h0);
      // Software keeps both stack pointers even
      wr(OFF_USTK, 32'h100);
      wr(OFF_ISTK, 32'h200);
      rc(OFF_ASTK, 32'h200);
      wr(OFF_FLAGW, 32'h80);
      rc(OFF_ASTK, 32'h100);
      wr(OFF_FLAGW, 32'hc0);
      wr(OFF_IPTR, 32'h123456);
      wr(OFF_FVEC, 32'habcdef);
      wr(OFF_CTRL, 32'h1);
      rc(OFF_FSAVE, 32'hc0);
      rc(OFF_PSAVE, 32'h123456);
      rc(OFF_IPTR, 32'habcdef);
      chk({31'h0, fast_irq_active}, 32'h1);
      wr(OFF_CTRL, 32'h2);
      rc(OFF_IPTR, 32'h123456);
      rc(OFF_FLAGW, 32'hc0);
      chk({31'h0, fast_irq_active}, 32'h0);
      wr(OFF_FLAGW, 32'h0);
      // Address generation: fixed vector, special page, wrap, signed offset, program
      wr(OFF_EACMD, 32'h00040000);
      rc(OFF_EARES, 32'h04ffffdc);
      wr(OFF_EACMD, 32'h00050001);
      rc(OFF_EARES, 32'h03fffe02);
      wr(OFF_SBASE, 32'hfffffe);
      wr(OFF_EACMD, 32'h00020004);
      rc(OFF_EARES, 32'h00000002);
      wr(OFF_FBASE, 32'h400);
      wr(OFF_EACMD, 32'h0003ffff);
      rc(OFF_EARES, 32'h000003ff);
      wr(OFF_ADDR0, 32'hfe0000);
      wr(OFF_EACMD, 32'h0);
      rc(OFF_EARES, 32'h02fe0000);
      // Second address register and the active stack pointer as bases
      wr(OFF_EACMD, 32'h00010401);
      rc(OFF_EARES, 32'h01000400);
      wr(OFF_EACMD, 32'h00060400);
      rc(OFF_EARES, 32'h01000600);
      wr(OFF_ADDR0, 32'h2c00);
      wr(OFF_PMODE, 32'h1);
      wr(OFF_EACMD, 32'h0);
      rc(OFF_EARES, 32'h09002c00);
      wr(OFF_PMODE, 32'h2);
      wr(OFF_EACMD, 32'h0);
      rc(OFF_EARES, 32'h09002c00);
      wr(OFF_PMODE, 32'h0);
      wr(OFF_EACMD, 32'h0);
      rc(OFF_EARES, 32'h01002c00);
      wr(8'h70, 32'h1);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      rc(8'h02, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      // Falling pin fires with interrupts disabled; rising edge must not
      nmi_pin <= 1'h0;
      repeat (6) @(posedge aclk);
      chk({31'h0, nmi_pending}, 32'h1);
      nmi_pin <= 1'h1;
      wr(OFF_STAT, 32'h1);
      repeat (6) @(posedge aclk);
      rc(OFF_STAT, 32'h0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
